// >>> design/reset_seq_pkg.sv
package reset_seq_pkg;

	// reference clock rate
	localparam int unsigned CLK_FREQ_HZ = 10_000_000;
	localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;

	// longest time from reset request release to lock indication
	localparam int unsigned LOCK_MAX_US = 10;
	localparam int unsigned LOCK_MAX_CYCLES = (LOCK_MAX_US * 1000) / CLK_PERIOD_NS;

	// lock settle delay after release, well inside the longest time
	localparam int unsigned LOCK_DELAY_CYCLES = 32;

	// lock held low after the internal watchdog reset ends, in reference clocks
	localparam int unsigned WDOG_HOLD_CYCLES = 24;

	// internal watchdog reset pulse length
	localparam int unsigned WDOG_RESET_CYCLES = 4;

	localparam int unsigned CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

	localparam int unsigned STRAP_W = 25;
	localparam logic [STRAP_W-1:0] STRAP_RESET = 25'h0000000;

	// position of the warm reset flag in the timer status word
	localparam int unsigned WARM_FLAG_BIT = 4;
	localparam int unsigned TSTAT_W = 8;
	localparam logic [TSTAT_W-1:0] TSTAT_RESET = 8'h00;

	typedef enum logic [1:0] {
		CAUSE_COLD,
		CAUSE_WARM,
		CAUSE_SOFT
	} reset_cause_type;

	typedef struct packed {
		logic core_reset;
		logic pll_reset;
		logic boot_go;
		logic lock;
	} reset_out_type;

endpackage : reset_seq_pkg

// >>> design/sync2.sv
`timescale 1ns/1ps
module sync2 (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// reset value 0 so a held-low reset pin reads asserted from the start
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule : sync2

// >>> design/reset_sequence_and_strap_capture.sv
// Summary of operation
// - Lock rises within 10 us of reset request rising, and boot waits for lock.
// - The straps are latched when reset request rises.
// - Lock drops at the next edge on a watchdog event, and two clocks later on reset request or power-on reset.
// - Lock stays low about 24 reference clocks after the watchdog reset ends.
// - Warm reset returns the sequencer to hold with the core in reset; the clock loop keeps running and the straps are latched again when reset request rises.
// - The warm flag reads 1 after a watchdog reset and 0 after a warm or cold reset.
`timescale 1ns/1ps
module reset_sequence_and_strap_capture
	import reset_seq_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic power_on_reset_n,
	input wire logic reset_request_n,
	input wire logic watchdog_event,
	input wire logic [STRAP_W-1:0] expansion_address_straps,
	output reset_out_type reset_out,
	output logic [STRAP_W-1:0] strap_config,
	output logic [TSTAT_W-1:0] timer_status
);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	// two flops on both reset pins add two clocks to their lock and drop times, but no logic sees them metastable

	logic por_n_s;
	logic req_n_s;

	sync2 u_sync_por (
		.clk_sys(clk_sys),
		.rst(rst),
		.async_in(power_on_reset_n),
		.sync_out(por_n_s)
	);

	sync2 u_sync_req (
		.clk_sys(clk_sys),
		.rst(rst),
		.async_in(reset_request_n),
		.sync_out(req_n_s)
	);

	// straps share the same two-flop path so they line up with the request edge
	logic [STRAP_W-1:0] strap_m_q;
	logic [STRAP_W-1:0] strap_m_d;
	logic [STRAP_W-1:0] strap_s_q;
	logic [STRAP_W-1:0] strap_s_d;

	always_comb begin
		strap_m_d = expansion_address_straps;
		strap_s_d = strap_m_q;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			strap_m_q <= STRAP_RESET;
			strap_s_q <= STRAP_RESET;
		end else begin
			strap_m_q <= strap_m_d;
			strap_s_q <= strap_s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	// core held in reset and boot blocked until the sequence has run
	localparam reset_out_type OUT_RESET = '{
		core_reset: 1'b1,
		pll_reset: 1'b1,
		boot_go: 1'b0,
		lock: 1'b0
	};

	typedef enum logic [2:0] {
		ST_COLD,
		ST_HOLD,
		ST_LOCK_WAIT,
		ST_RUN,
		ST_WDOG,
		ST_WDOG_HOLD
	} seq_state_type;

	seq_state_type state_q;
	seq_state_type state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic req_n_prev_q;
	logic req_n_prev_d;
	reset_cause_type cause_q;
	reset_cause_type cause_d;
	logic pll_running_q;
	logic pll_running_d;
	logic [STRAP_W-1:0] strap_q;
	logic [STRAP_W-1:0] strap_d;
	reset_out_type out_q;
	reset_out_type out_d;
	logic [TSTAT_W-1:0] tstat_q;
	logic [TSTAT_W-1:0] tstat_d;
	logic req_rise;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		cause_d = cause_q;
		pll_running_d = pll_running_q;
		strap_d = strap_q;
		tstat_d = tstat_q;
		req_n_prev_d = req_n_s;
		// edge taken from the synchronised copy, never from the pin
		req_rise = req_n_s & ~req_n_prev_q;
		out_d = out_q;

		if (!por_n_s) begin
			// cold: the clock loop restarts as well
			state_d = ST_COLD;
			cause_d = CAUSE_COLD;
			pll_running_d = 1'b0;
			cnt_d = CNT_ZERO;
		end else if (!req_n_s) begin
			// warm: the clock loop is left running, so relock is quicker
			state_d = ST_HOLD;
			// only a loop that has locked once makes this warm; a request that
			// toggles during the cold sequence must not cut the cold settle time
			if (pll_running_q) begin
				cause_d = CAUSE_WARM;
			end
			cnt_d = CNT_ZERO;
		end else begin
			unique case (state_q)
				ST_COLD, ST_HOLD: begin
					if (req_rise) begin
						strap_d = strap_s_q;
						state_d = ST_LOCK_WAIT;
						cnt_d = CNT_ZERO;
					end
				end
				ST_LOCK_WAIT: begin
					cnt_d = cnt_q + CNT_ONE;
					// a running clock loop needs no settle time
					if (pll_running_q || cnt_q == CNT_W'(LOCK_DELAY_CYCLES - 1)) begin
						state_d = ST_RUN;
						pll_running_d = 1'b1;
					end
				end
				ST_RUN: begin
					// a watchdog outside run is ignored, the core is already held in every state but watchdog hold
					if (watchdog_event) begin
						state_d = ST_WDOG;
						cause_d = CAUSE_SOFT;
						cnt_d = CNT_ZERO;
					end
				end
				ST_WDOG: begin
					// internal watchdog reset: core held, clock loop untouched
					cnt_d = cnt_q + CNT_ONE;
					if (cnt_q == CNT_W'(WDOG_RESET_CYCLES - 1)) begin
						state_d = ST_WDOG_HOLD;
						cnt_d = CNT_ZERO;
					end
				end
				ST_WDOG_HOLD: begin
					// core released, lock still low while the core settles
					cnt_d = cnt_q + CNT_ONE;
					if (cnt_q == CNT_W'(WDOG_HOLD_CYCLES - 1)) begin
						state_d = ST_RUN;
					end
				end
				// an illegal code falls back to the cold state, with the clock loop left running if it was
				default: begin
					state_d = ST_COLD;
				end
			endcase
		end

		// warm flag follows the cause of the last reset
		tstat_d = TSTAT_RESET;
		tstat_d[WARM_FLAG_BIT] = (cause_d == CAUSE_SOFT);

		// lock is computed from the next state so it drops in the same edge
		out_d.lock = (state_d == ST_RUN);
		// boot released by the same term as lock, so it can never lead it
		out_d.boot_go = (state_d == ST_RUN);
		out_d.core_reset = (state_d != ST_RUN) && (state_d != ST_WDOG_HOLD);
		out_d.pll_reset = ~pll_running_d;
	end

	// register only; every next value comes from the process above
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= ST_COLD;
			cnt_q <= CNT_ZERO;
			cause_q <= CAUSE_COLD;
			pll_running_q <= 1'b0;
			strap_q <= STRAP_RESET;
			tstat_q <= TSTAT_RESET;
			req_n_prev_q <= 1'b0;
			out_q <= OUT_RESET;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			cause_q <= cause_d;
			pll_running_q <= pll_running_d;
			strap_q <= strap_d;
			tstat_q <= tstat_d;
			req_n_prev_q <= req_n_prev_d;
			out_q <= out_d;
		end
	end

	assign reset_out = out_q;
	assign strap_config = strap_q;
	assign timer_status = tstat_q;

endmodule : reset_sequence_and_strap_capture

// >>> test/reset_seq_props.sv
`timescale 1ns/1ps
module reset_seq_props
	import reset_seq_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic power_on_reset_n,
	input wire logic reset_request_n,
	input wire logic watchdog_event,
	input wire logic [STRAP_W-1:0] expansion_address_straps,
	input wire reset_out_type reset_out,
	input wire logic [STRAP_W-1:0] strap_config,
	input wire logic [TSTAT_W-1:0] timer_status
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	property p_lock_time; $rose(reset_request_n) && power_on_reset_n |-> ##[1:99] reset_out.lock; endproperty
	a_lock_time: assert property (p_lock_time) else $error("lock late");
	// watchdog recovery sets the flag, so only request-driven locks must show the pins
	property p_strap; $rose(reset_out.lock) && !timer_status[WARM_FLAG_BIT] |-> strap_config == expansion_address_straps; endproperty
	a_strap: assert property (p_strap) else $error("straps not latched");
	property p_req_drop; $fell(reset_request_n) |-> ##[1:3] !reset_out.lock; endproperty
	a_req_drop: assert property (p_req_drop) else $error("lock kept on request");
	property p_wd_drop; watchdog_event && reset_out.lock |=> !reset_out.lock && !reset_out.boot_go; endproperty
	a_wd_drop: assert property (p_wd_drop) else $error("lock kept on watchdog");
	property p_wd_hold; watchdog_event && reset_out.lock |=> !reset_out.lock [*8] ##[12:24] $rose(reset_out.lock); endproperty
	a_wd_hold: assert property (p_wd_hold) else $error("watchdog hold wrong");
	property p_warm; $fell(reset_request_n) && power_on_reset_n && reset_out.lock |-> ##[1:4] reset_out.core_reset && !reset_out.pll_reset; endproperty
	a_warm: assert property (p_warm) else $error("warm reset wrong");
	property p_flag; watchdog_event && reset_out.lock |=> timer_status == 8'h10; endproperty
	a_flag: assert property (p_flag) else $error("warm flag not set");
	// a two-flop synchronised pin cannot move lock within the next two edges
	property p_sync; $fell(reset_request_n) |=> $stable(reset_out.lock) [*2]; endproperty
	a_sync: assert property (p_sync) else $error("pin used unsynchronised");
	c_cold: cover property ($rose(reset_out.lock) && !timer_status[WARM_FLAG_BIT]);
	c_wd: cover property (watchdog_event && reset_out.lock);
	c_warm: cover property ($fell(reset_request_n) && power_on_reset_n);
endmodule : reset_seq_props
bind reset_sequence_and_strap_capture reset_seq_props props_u (.clk_sys, .rst, .power_on_reset_n,
	.reset_request_n, .watchdog_event, .expansion_address_straps, .reset_out, .strap_config,
	.timer_status);

// >>> test/board_supervisor.sv
`timescale 1ns/1ps
module board_supervisor
	import reset_seq_pkg::*;
(
	input wire logic clk_sys,
	input wire logic lock,
	output logic power_on_reset_n,
	output logic reset_request_n,
	output logic [STRAP_W-1:0] expansion_address_straps
);
	initial begin
		power_on_reset_n = 1'b0;
		reset_request_n = 1'b0;
		expansion_address_straps = STRAP_RESET;
	end
	// lock read at the falling edge to stay clear of the register update
	task automatic wait_lock(output int n);
		n = 0;
		while (!lock && n < 200) begin
			@(negedge clk_sys);
			n++;
		end
		@(posedge clk_sys);
		expansion_address_straps <= STRAP_RESET;
	endtask : wait_lock
	task automatic cold(input logic [STRAP_W-1:0] v, output int n);
		@(posedge clk_sys);
		power_on_reset_n <= 1'b0;
		reset_request_n <= 1'b0;
		repeat (20) @(posedge clk_sys);
		power_on_reset_n <= 1'b1;
		expansion_address_straps <= v;
		@(posedge clk_sys);
		reset_request_n <= 1'b1;
		wait_lock(n);
	endtask : cold
	task automatic warm(input logic [STRAP_W-1:0] v, output int n);
		@(posedge clk_sys);
		reset_request_n <= 1'b0;
		expansion_address_straps <= v;
		repeat (5) @(posedge clk_sys);
		reset_request_n <= 1'b1;
		wait_lock(n);
	endtask : warm
endmodule : board_supervisor

// >>> test/test_reset_sequence_and_strap_capture.sv
`timescale 1ns/1ps
module test_reset_sequence_and_strap_capture
	import reset_seq_pkg::*;
;
	logic clk_sys, rst, watchdog_event, power_on_reset_n, reset_request_n;
	logic [STRAP_W-1:0] expansion_address_straps, strap_config;
	reset_out_type reset_out;
	logic [TSTAT_W-1:0] timer_status;
	int mismatches = 0, checked = 0, cycles = 0, n;
	board_supervisor sup_u (.clk_sys, .lock(reset_out.lock), .power_on_reset_n,
		.reset_request_n, .expansion_address_straps);
	reset_sequence_and_strap_capture dut_u (.clk_sys, .rst, .power_on_reset_n, .reset_request_n,
		.watchdog_event, .expansion_address_straps, .reset_out, .strap_config, .timer_status);
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// whole run needs fewer than 200 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			results();
		end
	end
	task automatic results;
		if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_settled(input logic [STRAP_W-1:0] v, input bit is_cold);
		chk("lock time", 32'(n <= LOCK_MAX_CYCLES), 32'h1);
		chk("relock", 32'(is_cold ? n >= LOCK_DELAY_CYCLES : n < LOCK_DELAY_CYCLES), 32'h1);
		@(negedge clk_sys);
		chk("outputs", 32'(reset_out), 32'h3);
		chk("straps", 32'(strap_config), 32'(v));
		chk("status", 32'(timer_status), 32'h0);
	endtask : t_settled
	task automatic t_wdog;
		@(posedge clk_sys);
		watchdog_event <= 1'b1;
		@(posedge clk_sys);
		watchdog_event <= 1'b0;
		@(negedge clk_sys);
		chk("wdog outputs", 32'(reset_out), 32'h8);
		chk("wdog status", 32'(timer_status), 32'h10);
		n = 0;
		while (!reset_out.lock && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		chk("wdog hold", 32'(n >= 24 && n <= 32), 32'h1);
	endtask : t_wdog
	initial begin
		rst = 1'b1;
		watchdog_event = 1'b0;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		sup_u.cold(25'h0A5A5A5, n);
		t_settled(25'h0A5A5A5, 1'b1);
		t_wdog();
		sup_u.warm(25'h1234567, n);
		t_settled(25'h1234567, 1'b0);
		sup_u.cold(25'h1FFFFFF, n);
		t_settled(25'h1FFFFFF, 1'b1);
		results();
	end
endmodule : test_reset_sequence_and_strap_capture
